// *** verilog/slulc_top.sv ***
// serial line unit with line tick: axi4-lite registers, uart transmitter and receiver, mains tick
//
// Contract
// - tx_data_buffer write clears transmitter ready
// - idle transmitter: ready returns within one cycle
// - start bit, data bits, stop bits
// - double buffered; ready once holding moves
// - eight data bits make eleven-bit frame
// - ready and enable request transmit interrupt
// - start bit begins bit-by-bit assembly
// - full character to buffer, set done
// - done and enable request receive interrupt
// - reader advance set clears done, drives out
// - next start bit clears reader advance
// - active set at start bit middle
// - active cleared as done sets
// - switch plus break bit force space
// - loopback feeds transmitter into receiver
// - loopback keeps external line idle
// - ready and send-request held asserted
// - tick flag set per cycle, host clears
// - tick period equals mains period
// - tick enable requests interrupt each cycle
// - receiver and transmitter run independently
//
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
module slulc_top
   import slulc_pkg::*;
#(
   parameter int BAUD      = `SLULC_BAUD,        // line rate in bits per second
   parameter int STOP_BITS = `SLULC_STOP_BITS,   // stop bits per frame
   parameter int CLK_HZ    = `SLULC_CLK_HZ       // system clock rate
) (
   input  wire logic                     aclk,
   input  wire logic                     aresetn,
   input  wire logic [`SLULC_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                     s_axi_awvalid,
   output logic                          s_axi_awready,
   input  wire logic [31:0]              s_axi_wdata,
   input  wire logic [3:0]               s_axi_wstrb,
   input  wire logic                     s_axi_wvalid,
   output logic                          s_axi_wready,
   output logic [1:0]                    s_axi_bresp,
   output logic                          s_axi_bvalid,
   input  wire logic                     s_axi_bready,
   input  wire logic [`SLULC_ADDR_W-1:0] s_axi_araddr,
   input  wire logic                     s_axi_arvalid,
   output logic                          s_axi_arready,
   output logic [31:0]                   s_axi_rdata,
   output logic [1:0]                    s_axi_rresp,
   output logic                          s_axi_rvalid,
   input  wire logic                     s_axi_rready,
   input  wire logic                     rxd,
   output logic                          txd,
   input  wire logic                     break_switch_en,
   input  wire logic                     mains_square,
   output logic                          reader_advance,
   output logic                          data_terminal_ready,
   output logic                          request_to_send,
   output logic                          rx_irq,
   output logic                          tx_irq,
   output logic                          tick_irq
);

   // one bit time in clocks, and half of it for start bit centring
   localparam int CPB_I = CLK_HZ / BAUD;
   localparam logic [`SLULC_CNT_W-1:0] CPB  = CPB_I[`SLULC_CNT_W-1:0];
   localparam logic [`SLULC_CNT_W-1:0] HALF = CPB >> 1;
   localparam int FRAME_I = 1 + `SLULC_DATA_BITS + STOP_BITS;
   localparam logic [3:0] FRAME_BITS = FRAME_I[3:0];   // bits per frame
   localparam logic [3:0] DATA_BITS  = 4'h8;           // data bits per frame

   slulc_state_t s_q;   // every flip-flop of the block
   slulc_state_t s_d;   // next value of the record

   logic tx_line;   // transmitter serial output before routing
   logic rx_line;   // receiver serial input after routing
   logic wr_go;     // address and data both held: perform the write
   logic rd_go;     // read address taken this cycle

   // read view of a register; unmapped addresses give zero and an error flag
   function automatic logic [32:0] rd_decode(input slulc_state_t s, input logic [`SLULC_ADDR_W-1:0] a);
      logic [31:0] v;
      logic        err;
      v   = 32'h0;
      err = 1'b0;
      case (a)
         `SLULC_OFF_RCSR: begin
            v[`SLULC_B_RDR]  = s.rdr_en;
            v[`SLULC_B_IE]   = s.rx_ie;
            v[`SLULC_B_FLAG] = s.rx_done;
            v[`SLULC_B_ACT]  = s.rx_act;
         end
         `SLULC_OFF_RX_DATA_BUFFER: v[7:0] = s.rx_buf;
         `SLULC_OFF_XCSR: begin
            v[`SLULC_B_BRK]  = s.brk;
            v[`SLULC_B_LOOP] = s.loop;
            v[`SLULC_B_IE]   = s.tx_ie;
            v[`SLULC_B_FLAG] = ~s.hold_full;
         end
         `SLULC_OFF_TX_DATA_BUFFER: v[7:0] = 8'h0;   // write-only data path
         `SLULC_OFF_LKS: begin
            v[`SLULC_B_IE]   = s.lt_ie;
            v[`SLULC_B_FLAG] = s.lt_flag;
         end
         default: err = 1'b1;
      endcase
      return {err, v};
   endfunction

   // true when an address names one of the five registers
   function automatic logic mapped(input logic [`SLULC_ADDR_W-1:0] a);
      return (a == `SLULC_OFF_RCSR) || (a == `SLULC_OFF_RX_DATA_BUFFER) || (a == `SLULC_OFF_XCSR) ||
             (a == `SLULC_OFF_TX_DATA_BUFFER) || (a == `SLULC_OFF_LKS);
   endfunction

   // bus handshakes are combinational from held state
   assign s_axi_awready = ~s_q.aw_have & ~s_q.bvalid;
   assign s_axi_wready  = ~s_q.w_have & ~s_q.bvalid;
   assign s_axi_arready = ~s_q.rvalid;
   assign s_axi_bvalid  = s_q.bvalid;
   assign s_axi_bresp   = s_q.bresp;
   assign s_axi_rvalid  = s_q.rvalid;
   assign s_axi_rresp   = s_q.rresp;
   assign s_axi_rdata   = s_q.rdata;
   assign wr_go         = s_q.aw_have & s_q.w_have;
   assign rd_go         = s_axi_arvalid & ~s_q.rvalid;

   // break bit with the switch forces space, an idle shifter sits at mark
   assign tx_line = (s_q.brk & s_q.bk_s2) ? 1'b0 : (s_q.tx_st == SLULC_TX_SHIFT) ? s_q.tx_sh[0] : 1'b1;
   // loopback closes the path inside and parks the pin at mark
   assign rx_line = s_q.loop ? tx_line : s_q.rx_s2;
   assign txd     = s_q.loop ? 1'b1 : tx_line;

   // modem controls are strapped on; reader advance follows its enable
   assign data_terminal_ready = 1'b1;
   assign request_to_send     = 1'b1;
   assign reader_advance      = s_q.rdr_en;

   // interrupt requests are plain levels from flag and enable
   assign tx_irq   = ~s_q.hold_full & s_q.tx_ie;
   assign rx_irq   = s_q.rx_done & s_q.rx_ie;
   assign tick_irq = s_q.lt_flag & s_q.lt_ie;

   // next state of the whole block
   always_comb begin
      logic [32:0] rd;
      logic        rx_done_set;
      logic        lt_edge;
      logic        wr_en;
      rd          = rd_decode(s_q, s_axi_araddr);
      rx_done_set = 1'b0;
      lt_edge     = 1'b0;
      wr_en       = 1'b0;
      s_d         = s_q;

      // two-stage synchronisers; the mains input has a third stage for edge detection, the others are looked at on the second
      s_d.rx_s1 = rxd;
      s_d.rx_s2 = s_q.rx_s1;
      s_d.bk_s1 = break_switch_en;
      s_d.bk_s2 = s_q.bk_s1;
      s_d.lf_s1 = mains_square;
      s_d.lf_s2 = s_q.lf_s1;
      s_d.lf_s3 = s_q.lf_s2;

      // write channel: address and data captured in either order
      if (s_axi_awvalid && s_axi_awready) begin
         s_d.aw_have = 1'b1;
         s_d.awaddr  = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         s_d.w_have = 1'b1;
         s_d.wdata  = s_axi_wdata;
         s_d.wstrb0 = s_axi_wstrb[0];
      end
      if (wr_go) begin
         s_d.aw_have = 1'b0;
         s_d.w_have  = 1'b0;
         s_d.bvalid  = 1'b1;
         s_d.bresp   = mapped(s_q.awaddr) ? `SLULC_RESP_OKAY : `SLULC_RESP_SLVERR;
         wr_en       = s_q.wstrb0;   // all control bits live in byte lane 0
      end
      if (s_q.bvalid && s_axi_bready) begin
         s_d.bvalid = 1'b0;
      end

      // read channel: one cycle to registered data
      if (rd_go) begin
         s_d.rvalid = 1'b1;
         s_d.rdata  = rd[31:0];
         s_d.rresp  = rd[32] ? `SLULC_RESP_SLVERR : `SLULC_RESP_OKAY;
      end else if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid = 1'b0;
      end

      // register writes; hardware sets further down take priority over clears
      if (wr_en) begin
         case (s_q.awaddr)
            `SLULC_OFF_RCSR: begin
               s_d.rx_ie = s_q.wdata[`SLULC_B_IE];
               if (s_q.wdata[`SLULC_B_RDR]) begin
                  s_d.rdr_en  = 1'b1;
                  s_d.rx_done = 1'b0;
               end
            end
            `SLULC_OFF_XCSR: begin
               s_d.brk   = s_q.wdata[`SLULC_B_BRK];
               s_d.loop  = s_q.wdata[`SLULC_B_LOOP];
               s_d.tx_ie = s_q.wdata[`SLULC_B_IE];
            end
            `SLULC_OFF_TX_DATA_BUFFER: begin
               s_d.tx_hold   = s_q.wdata[7:0];
               s_d.hold_full = 1'b1;
            end
            `SLULC_OFF_LKS: begin
               s_d.lt_ie = s_q.wdata[`SLULC_B_IE];
               if (!s_q.wdata[`SLULC_B_FLAG]) begin
                  s_d.lt_flag = 1'b0;
               end
            end
            default: begin
               s_d.lt_ie = s_q.lt_ie;   // unmapped: nothing stored
            end
         endcase
      end

      // transmitter: holding register feeds the shifter when it is free
      unique case (s_q.tx_st)
         SLULC_TX_IDLE: begin
            if (s_q.hold_full) begin
               // frame built lsb first: start, data, then stop ones
               s_d.tx_sh     = {2'h3, s_q.tx_hold, 1'b0};
               s_d.hold_full = 1'b0;
               s_d.tx_cnt    = CPB;
               s_d.tx_bits   = FRAME_BITS;
               s_d.tx_st     = SLULC_TX_SHIFT;
            end
         end
         SLULC_TX_SHIFT: begin
            // one bit per bit time; ones fill behind for extra stop bits
            if (s_q.tx_cnt == `SLULC_CNT_W'(1)) begin
               s_d.tx_cnt = CPB;
               s_d.tx_sh  = {1'b1, s_q.tx_sh[10:1]};
               s_d.tx_bits = s_q.tx_bits - 4'h1;
               if (s_q.tx_bits == 4'h1) begin
                  s_d.tx_st = SLULC_TX_IDLE;
               end
            end else begin
               s_d.tx_cnt = s_q.tx_cnt - `SLULC_CNT_W'(1);
            end
         end
      endcase
      if (wr_en && s_q.awaddr == `SLULC_OFF_TX_DATA_BUFFER) begin
         s_d.hold_full = 1'b1;   // a new character beats the move of the old one
      end

      // receiver: runs beside the transmitter with its own counters
      unique case (s_q.rx_st)
         SLULC_RX_IDLE: begin
            if (!rx_line) begin
               s_d.rx_cnt = HALF;
               s_d.rx_st  = SLULC_RX_START;
            end
         end
         SLULC_RX_START: begin
            if (s_q.rx_cnt == `SLULC_CNT_W'(1)) begin
               if (!rx_line) begin
                  s_d.rx_act  = 1'b1;
                  s_d.rdr_en  = 1'b0;
                  s_d.rx_cnt  = CPB;
                  s_d.rx_bits = 4'h0;
                  s_d.rx_st   = SLULC_RX_DATA;
               end else begin
                  s_d.rx_st = SLULC_RX_IDLE;   // glitch, not a start bit
               end
            end else begin
               s_d.rx_cnt = s_q.rx_cnt - `SLULC_CNT_W'(1);
            end
         end
         SLULC_RX_DATA: begin
            if (s_q.rx_cnt == `SLULC_CNT_W'(1)) begin
               s_d.rx_cnt  = CPB;
               s_d.rx_sh   = {rx_line, s_q.rx_sh[7:1]};
               s_d.rx_bits = s_q.rx_bits + 4'h1;
               if (s_q.rx_bits == DATA_BITS - 4'h1) begin
                  s_d.rx_st = SLULC_RX_STOP;
               end
            end else begin
               s_d.rx_cnt = s_q.rx_cnt - `SLULC_CNT_W'(1);
            end
         end
         SLULC_RX_STOP: begin
            // framing is not checked; the character is delivered at mid stop bit
            if (s_q.rx_cnt == `SLULC_CNT_W'(1)) begin
               s_d.rx_buf  = s_q.rx_sh;
               rx_done_set = 1'b1;
               s_d.rx_st   = SLULC_RX_IDLE;
            end else begin
               s_d.rx_cnt = s_q.rx_cnt - `SLULC_CNT_W'(1);
            end
         end
      endcase
      if (rx_done_set) begin
         s_d.rx_done = 1'b1;
         s_d.rx_act  = 1'b0;
      end

      // one rising mains edge per cycle gives one tick
      lt_edge = s_q.lf_s2 & ~s_q.lf_s3;
      if (lt_edge) begin
         s_d.lt_flag = 1'b1;
      end
   end

   // single register stage; reset forces lines to mark and machines to idle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q       <= '0;
         s_q.rx_s1 <= 1'b1;
         s_q.rx_s2 <= 1'b1;
         s_q.rx_st <= SLULC_RX_IDLE;
         s_q.tx_st <= SLULC_TX_IDLE;
         s_q.tx_sh <= 11'h7ff;
      end else begin
         s_q <= s_d;
      end
   end

endmodule

// *** verilog/slulc_cfg.svh ***
// register map, field positions, response codes and timing figures of the serial line unit
`ifndef SLULC_CFG_SVH
`define SLULC_CFG_SVH
`define SLULC_CLK_HZ      10000000
`define SLULC_BAUD        110
`define SLULC_STOP_BITS   2
`define SLULC_DATA_BITS   8
`define SLULC_CNT_W       20
`define SLULC_ADDR_W      8
`define SLULC_OFF_RCSR    8'h00
`define SLULC_OFF_RX_DATA_BUFFER    8'h04
`define SLULC_OFF_XCSR    8'h08
`define SLULC_OFF_TX_DATA_BUFFER    8'h0c
`define SLULC_OFF_LKS     8'h10
`define SLULC_B_RDR       0
`define SLULC_B_BRK       0
`define SLULC_B_LOOP      2
`define SLULC_B_IE        6
`define SLULC_B_FLAG      7
`define SLULC_B_ACT       11
`define SLULC_RESP_OKAY   2'h0
`define SLULC_RESP_SLVERR 2'h2
`endif

// *** verilog/slulc_pkg.sv ***
// types and state record of the serial line unit with line tick
`include "slulc_cfg.svh"
package slulc_pkg;
   typedef enum logic [3:0] {
      SLULC_RX_IDLE  = 4'h1,
      SLULC_RX_START = 4'h2,
      SLULC_RX_DATA  = 4'h4,
      SLULC_RX_STOP  = 4'h8
   } slulc_rx_st_t;
   typedef enum logic [1:0] {
      SLULC_TX_IDLE  = 2'h1,
      SLULC_TX_SHIFT = 2'h2
   } slulc_tx_st_t;
   typedef struct packed {
      logic                      rx_s1;
      logic                      rx_s2;
      logic                      lf_s1;
      logic                      lf_s2;
      logic                      lf_s3;
      logic                      bk_s1;
      logic                      bk_s2;
      slulc_rx_st_t              rx_st;
      logic [`SLULC_CNT_W-1:0]   rx_cnt;
      logic [3:0]                rx_bits;
      logic [7:0]                rx_sh;
      logic [7:0]                rx_buf;
      logic                      rx_done;
      logic                      rx_act;
      logic                      rx_ie;
      logic                      rdr_en;
      slulc_tx_st_t              tx_st;
      logic [`SLULC_CNT_W-1:0]   tx_cnt;
      logic [3:0]                tx_bits;
      logic [10:0]               tx_sh;
      logic [7:0]                tx_hold;
      logic                      hold_full;
      logic                      tx_ie;
      logic                      brk;
      logic                      loop;
      logic                      lt_flag;
      logic                      lt_ie;
      logic                      aw_have;
      logic [`SLULC_ADDR_W-1:0]  awaddr;
      logic                      w_have;
      logic [31:0]               wdata;
      logic                      wstrb0;
      logic                      bvalid;
      logic [1:0]                bresp;
      logic                      rvalid;
      logic [1:0]                rresp;
      logic [31:0]               rdata;
   } slulc_state_t;
endpackage

// *** dv/slulc_assertions.sv ***
// port-level checks of the serial line unit
`timescale 1ns/1ps
module slulc_assertions (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic rxd,
   input wire logic txd,
   input wire logic reader_advance,
   input wire logic data_terminal_ready,
   input wire logic request_to_send,
   input wire logic rx_irq,
   input wire logic tx_irq,
   input wire logic tick_irq
);
   // one clock domain: one default clock and reset
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   modem_lines_a: assert property (data_terminal_ready && request_to_send)
      else $error("modem lines dropped");
   write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid) else $error("write response late");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response late");
   bus_refuse_a: assert property ((s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      and (s_axi_rvalid |-> !s_axi_arready)) else $error("request taken while answer pending");
   // no level on the line is shorter than eight clocks
   space_len_a: assert property ($fell(txd) |-> !txd [*8])
      else $error("space shorter than a bit");
   mark_len_a: assert property ($rose(txd) |-> txd [*8])
      else $error("mark shorter than a bit");
   // past reset term keeps a reset-driven drop out
   rdr_drop_a: assert property ($fell(reader_advance) && $past(aresetn) |-> !$past(rxd, 4))
      else $error("reader advance dropped without start bit");
   // flags fall only in the clock after a host write
   tick_hold_a: assert property (tick_irq && !s_axi_wvalid && !$past(s_axi_wvalid) |=> tick_irq)
      else $error("tick flag cleared by hardware");
   rx_hold_a: assert property (rx_irq && !s_axi_wvalid && !$past(s_axi_wvalid) |=> rx_irq)
      else $error("receive request dropped");
   tx_hold_a: assert property (tx_irq && !s_axi_wvalid && !$past(s_axi_wvalid) |=> tx_irq)
      else $error("transmit request dropped");
endmodule

// *** dv/slulc_term.sv ***
// serial terminal model: sends frames on rxd, decodes frames from txd
`timescale 1ns/1ps
module slulc_term #(
   parameter int CPB = 10  // clocks per bit
) (
   input  wire logic aclk,
   input  wire logic txd,
   output logic      rxd
);
   logic [7:0] got_q[$];  // decoded characters
   int         bad_stop;  // stop bits sampled low
   initial begin
      rxd = 1'b1;  // line rests at mark
      bad_stop = 0;
   end
   // one frame, lsb first, two stop bits; gap paces slow senders
   task automatic send(input logic [7:0] ch, input int gap);
      logic [10:0] f;
      f = {2'b11, ch, 1'b0};
      for (int i = 0; i < 11; i++) begin
         rxd <= f[i];
         repeat (CPB) @(posedge aclk);
      end
      repeat (gap) @(posedge aclk);
   endtask
   // decode by sampling mid-bit; no framing recovery, like a real terminal
   always begin
      logic [7:0] ch;
      @(negedge txd);
      repeat (CPB / 2) @(posedge aclk);
      for (int i = 0; i < 8; i++) begin
         repeat (CPB) @(posedge aclk);
         ch[i] = txd;
      end
      repeat (2) begin
         repeat (CPB) @(posedge aclk);
         if (txd !== 1'b1) bad_stop++;
      end
      got_q.push_back(ch);
   end
endmodule

// *** dv/slulc_top_tb.sv ***
// self-checking bench of the serial line unit with line tick
`timescale 1ns/1ps
`include "slulc_cfg.svh"
module slulc_top_tb;
   localparam int CPB = 10;   // clocks per bit at 1 Mbaud
   localparam int HMP = 200;  // half mains period in clocks, shortened
   logic        aclk, aresetn, txd, rxd, break_switch_en, mains_square;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic        reader_advance, data_terminal_ready, request_to_send, rx_irq, tx_irq, tick_irq;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, c;    // addresses, scratch character
   logic [31:0] s_axi_wdata, s_axi_rdata, rs, v;  // data, xorshift state, read word
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rp;     // rp: last response code
   logic [7:0]  txq[$];                           // characters given to the transmitter
   int          miscompares, num_checks, n;
   slulc_top #(.BAUD(1000000)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .rxd, .txd, .break_switch_en, .mains_square, .reader_advance,
      .data_terminal_ready, .request_to_send, .rx_irq, .tx_irq, .tick_irq);
   slulc_term #(.CPB(CPB)) term (.aclk, .txd, .rxd);
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   // mains square wave, free running
   initial forever begin
      repeat (HMP) @(posedge aclk);
      mains_square <= ~mains_square;
   end
   function automatic logic [31:0] rnd();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      num_checks++;
      if (s !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // write: address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_p, w_p, ta, tw;  // channels still offered, channels taken at the coming edge
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      aw_p = 1'b1;
      w_p  = 1'b1;
      // ready moves only at rising edges, so its mid-cycle value is what the next edge samples
      while (aw_p || w_p) begin
         @(negedge aclk);
         ta = aw_p & s_axi_awready;
         tw = w_p & s_axi_wready;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         aw_p = aw_p & ~ta;
         w_p  = w_p & ~tw;
      end
      do @(negedge aclk); while (!s_axi_bvalid);
      rp = s_axi_bresp;
      @(posedge aclk);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do @(negedge aclk); while (!s_axi_arready);
      @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      do @(negedge aclk); while (!s_axi_rvalid);
      v = s_axi_rdata;
      rp = s_axi_rresp;
      @(posedge aclk);
      s_axi_rready <= 1'b0;
   endtask
   task automatic wait_got(input int k);
      for (int i = 0; i < 30 * CPB && term.got_q.size() < k; i++) @(posedge aclk);
   endtask
   initial begin
      rs = 32'h00014dde;  // fixed seed
      miscompares = 0;
      num_checks = 0;
      {aresetn, break_switch_en, mains_square} = 3'h0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hf;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`SLULC_OFF_XCSR);
      chk("xcsr reset", 32'h80, v);
      rd(`SLULC_OFF_LKS);
      chk("lks reset", 32'h0, v);
      rd(8'h14);
      chk("unmapped read", {30'h0, `SLULC_RESP_SLVERR}, {30'h0, rp});
      wr(8'h14, 32'hff);
      chk("unmapped write", {30'h0, `SLULC_RESP_SLVERR}, {30'h0, rp});
      // back to back characters: the second waits in the holding register
      wr(`SLULC_OFF_XCSR, 32'h40);
      chk("tx irq on", 32'h1, {31'h0, tx_irq});
      repeat (2) begin
         txq.push_back(8'(rnd()));
         wr(`SLULC_OFF_TX_DATA_BUFFER, {24'h0, txq[$]});
      end
      rd(`SLULC_OFF_XCSR);
      chk("xcsr held", 32'h40, v);
      for (n = 0; n < 300 && !tx_irq; n++) @(posedge aclk);
      chk("ready on move", 32'h1, {31'h0, n > 6 * CPB && n < 11 * CPB});
      wait_got(2);
      // receive while transmitting
      wr(`SLULC_OFF_RCSR, 32'h40);
      for (int i = 0; i < 3; i++) begin
         c = 8'(rnd());
         fork
            term.send(c, 0);
            begin
               txq.push_back(8'(rnd()));
               wr(`SLULC_OFF_TX_DATA_BUFFER, {24'h0, txq[$]});
               repeat (CPB) @(posedge aclk);
               rd(`SLULC_OFF_RCSR);
               chk("rx active", (i == 0) ? 32'h840 : 32'h8c0, v);
            end
         join
         chk("rx irq", 32'h1, {31'h0, rx_irq});
         rd(`SLULC_OFF_RX_DATA_BUFFER);
         chk("rx char", {24'h0, c}, v);
         rd(`SLULC_OFF_RCSR);
         chk("rx done", 32'hc0, v);
      end
      wait_got(5);
      foreach (txq[i]) chk("tx char", {24'h0, txq[i]}, {24'h0, term.got_q[i]});
      chk("stop bits", 32'h0, 32'(term.bad_stop));
      // reader advance asks for one character
      wr(`SLULC_OFF_RCSR, 32'h41);
      chk("rdr out", 32'h1, {31'h0, reader_advance});
      chk("rdr clears done", 32'h0, {31'h0, rx_irq});
      term.send(8'(rnd()), int'(rnd() & 32'h7));
      chk("rdr dropped", 32'h0, {31'h0, reader_advance});
      // loopback keeps the line at mark and feeds the receiver
      wr(`SLULC_OFF_XCSR, 32'h44);
      c = 8'(rnd());
      wr(`SLULC_OFF_TX_DATA_BUFFER, {24'h0, c});
      rd(`SLULC_OFF_XCSR);
      chk("idle tx ready", 32'hc4, v);
      n = 0;
      repeat (12 * CPB) begin
         @(posedge aclk);
         n += int'(txd !== 1'b1);
      end
      chk("line at mark", 32'h0, 32'(n));
      rd(`SLULC_OFF_RX_DATA_BUFFER);
      chk("loop char", {24'h0, c}, v);
      // break needs the strap as well as the control bit
      wr(`SLULC_OFF_XCSR, 32'h41);
      chk("break blocked", 32'h1, {31'h0, txd});
      break_switch_en <= 1'b1;
      repeat (12) @(posedge aclk);
      chk("break space", 32'h0, {31'h0, txd});
      wr(`SLULC_OFF_XCSR, 32'h40);
      break_switch_en <= 1'b0;
      chk("break off", 32'h1, {31'h0, txd});
      // tick: once per mains cycle, cleared only by the host
      wr(`SLULC_OFF_LKS, 32'h40);
      @(posedge mains_square);
      for (int i = 0; i < 10 && !tick_irq; i++) @(posedge aclk);
      chk("tick", 32'h1, {31'h0, tick_irq});
      rd(`SLULC_OFF_LKS);
      chk("tick flag", 32'hc0, v);
      wr(`SLULC_OFF_LKS, 32'h40);
      chk("tick cleared", 32'h0, {31'h0, tick_irq});
      repeat (2 * HMP - 40) @(posedge aclk);
      chk("one tick a cycle", 32'h0, {31'h0, tick_irq});
      for (int i = 0; i < 60 && !tick_irq; i++) @(posedge aclk);
      chk("next tick", 32'h1, {31'h0, tick_irq});
      stop_test();
   end
   // cuts a hang short
   initial begin
      repeat (20000) @(posedge aclk);
      miscompares++;
      stop_test();
   end
endmodule
bind slulc_top slulc_assertions chk_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .rxd, .txd,
   .reader_advance, .data_terminal_ready, .request_to_send, .rx_irq, .tx_irq, .tick_irq);
